// *** fhv_pkg.sv ***
// package for the frame header and output volume register group
// assumes an 8-bit register port driven by the control-bus slave logic
package fhv_pkg;

  // ==========================================================
  // register addresses
  localparam logic [7:0] FHV_ADDR_ANC_LOW   = 8'h41;
  localparam logic [7:0] FHV_ADDR_ANC_HIGH  = 8'h42;
  localparam logic [7:0] FHV_ADDR_HDR_UPPER = 8'h43;
  localparam logic [7:0] FHV_ADDR_HDR_MID   = 8'h44;
  localparam logic [7:0] FHV_ADDR_HDR_LOWER = 8'h45;
  localparam logic [7:0] FHV_ADDR_LEFT_VOL  = 8'h46;
  localparam logic [7:0] FHV_ADDR_XFEED     = 8'h47;
  localparam logic [7:0] FHV_ADDR_RIGHT_VOL = 8'h48;

  // ==========================================================
  // reset values and attenuation mute threshold
  localparam logic [7:0]  FHV_RST_VOL   = 8'h00;
  localparam logic [7:0]  FHV_RST_XFEED = 8'hFF;
  localparam logic [15:0] FHV_RST_ANC   = 16'h0000;
  localparam logic [20:0] FHV_RST_HDR   = 21'h000000;
  localparam logic [7:0]  FHV_ATT_MUTE  = 8'h60;

  // ==========================================================
  // header field positions
  localparam int FHV_POS_EMPH    = 0;
  localparam int FHV_POS_ORIG    = 2;
  localparam int FHV_POS_COPY    = 3;
  localparam int FHV_POS_MODEXT  = 4;
  localparam int FHV_POS_MODE    = 6;
  localparam int FHV_POS_PRIV    = 8;
  localparam int FHV_POS_PAD     = 9;
  localparam int FHV_POS_SRATE   = 10;
  localparam int FHV_POS_BRATE   = 12;
  localparam int FHV_POS_PROT    = 16;
  localparam int FHV_POS_LAYER   = 17;
  localparam int FHV_POS_VER     = 19;
  localparam int FHV_POS_VEREXT  = 20;
  localparam logic [1:0] FHV_LAYER_III = 2'h1;

  // ==========================================================
  // decoded enumerations
  typedef enum logic [1:0] {
    FHV_MPEG25 = 2'b00,
    FHV_MPEG_RSV = 2'b01,
    FHV_MPEG2 = 2'b10,
    FHV_MPEG1 = 2'b11
  } fhv_ver_e;

  typedef enum logic [1:0] {
    FHV_STEREO = 2'b00,
    FHV_JOINT = 2'b01,
    FHV_DUAL = 2'b10,
    FHV_MONO = 2'b11
  } fhv_chmode_e;

  typedef enum logic [1:0] {
    FHV_EMPH_NONE = 2'b00,
    FHV_EMPH_50_15 = 2'b01,
    FHV_EMPH_RSV = 2'b10,
    FHV_EMPH_J17 = 2'b11
  } fhv_emph_e;

  // register port request
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } fhv_req_s;

  // decoded view of the stored header
  typedef struct packed {
    fhv_ver_e    version;
    logic        layer_ok;
    logic        crc_present;
    logic [8:0]  bitrate_kbps;
    logic        free_format;
    logic        bad_bitrate;
    logic [15:0] srate_10hz;
    logic        bad_srate;
    logic        extra_slot;
    fhv_chmode_e chmode;
    logic [1:0]  joint_method;
    logic        copyright;
    logic        original;
    fhv_emph_e   emphasis;
    logic        priv;
  } fhv_hdr_s;

  // ==========================================================
  // attenuation gain: 1 dB steps, saturating to mute at 96 dB and above
  function automatic logic [15:0] fhv_att_gain(input logic [7:0] att);
    logic [15:0] g;
    logic [3:0]  f;
    g = 16'h0000;
    f = 4'h0;
    if (att < FHV_ATT_MUTE) begin
      // 6 dB per halving, residual via table of 2^(-k/6)
      f = 4'(att % 8'd6);
      case (f)
        4'h0: g = 16'hFFFF;
        4'h1: g = 16'hE402;
        4'h2: g = 16'hCB59;
        4'h3: g = 16'hB53C;
        4'h4: g = 16'hA18A;
        default: g = 16'h8FF6;
      endcase
      g = g >> (att / 8'd6);
    end
    return g;
  endfunction

endpackage

// *** fhv_regs.sv ***
// frame header and output volume registers, audio volume/crossfeed path
// assumes register port and frame events synchronous to clk_i
`timescale 1ns/1ps

module fhv_regs
  import fhv_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        srst_i,
  input  wire logic        soft_rst_i,
  input  wire fhv_req_s    req_i,
  output logic [7:0]       rdata_o,
  output logic             rvalid_o,
  input  wire logic        frame_ok_i,
  input  wire logic [15:0] anc_bits_i,
  input  wire logic        sync_i,
  input  wire logic [20:0] header_i,
  input  wire logic        smp_valid_i,
  input  wire logic [15:0] left_i,
  input  wire logic [15:0] right_i,
  output logic [15:0]      left_o,
  output logic [15:0]      right_o,
  output logic             out_valid_o,
  output fhv_hdr_s         hdr_o
);

  // ==========================================================
  // state
  logic        rst;
  logic [15:0] anc_q;
  logic [20:0] hdr_q;
  logic [7:0]  lvol_q;
  logic [7:0]  xfeed_q;
  logic [7:0]  rvol_q;
  logic [7:0]  rdata_d;
  logic        hit;

  assign rst = srst_i | soft_rst_i;

  // ==========================================================
  // ancillary count
  always_ff @(posedge clk_i) begin
    if (rst) begin
      anc_q <= FHV_RST_ANC;
    end else if (frame_ok_i) begin
      anc_q <= anc_bits_i;
    end
  end

  // ==========================================================
  // header capture
  always_ff @(posedge clk_i) begin
    if (rst) begin
      hdr_q <= FHV_RST_HDR;
    end else if (sync_i) begin
      hdr_q <= header_i;
    end
  end

  // ==========================================================
  // writable attenuators
  always_ff @(posedge clk_i) begin
    if (rst) begin
      lvol_q  <= FHV_RST_VOL;
      xfeed_q <= FHV_RST_XFEED;
      rvol_q  <= FHV_RST_VOL;
    end else if (req_i.wr) begin
      case (req_i.addr)
        FHV_ADDR_LEFT_VOL:  lvol_q  <= req_i.wdata;
        FHV_ADDR_XFEED:     xfeed_q <= req_i.wdata;
        FHV_ADDR_RIGHT_VOL: rvol_q  <= req_i.wdata;
        default: ;
      endcase
    end
  end

  // ==========================================================
  // read decode; unmapped addresses read zero
  always_comb begin
    rdata_d = 8'h00;
    hit = 1'b1;
    case (req_i.addr)
      FHV_ADDR_ANC_LOW:   rdata_d = anc_q[7:0];
      FHV_ADDR_ANC_HIGH:  rdata_d = anc_q[15:8];
      // upper bits above 20 read zero
      FHV_ADDR_HDR_UPPER: rdata_d = {3'b000, hdr_q[20:16]};
      FHV_ADDR_HDR_MID:   rdata_d = hdr_q[15:8];
      FHV_ADDR_HDR_LOWER: rdata_d = hdr_q[7:0];
      FHV_ADDR_LEFT_VOL:  rdata_d = lvol_q;
      FHV_ADDR_XFEED:     rdata_d = xfeed_q;
      FHV_ADDR_RIGHT_VOL: rdata_d = rvol_q;
      default:            hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rdata_o  <= 8'h00;
      rvalid_o <= 1'b0;
    end else begin
      rdata_o  <= (req_i.rd && hit) ? rdata_d : 8'h00;
      rvalid_o <= req_i.rd;
    end
  end

  // ==========================================================
  // header decode
  logic [1:0] ver_bits;
  logic [3:0] br_idx;
  logic [1:0] sr_idx;
  logic [8:0] br;
  logic [15:0] sr;

  assign ver_bits = {hdr_q[FHV_POS_VEREXT], hdr_q[FHV_POS_VER]};
  assign br_idx   = hdr_q[FHV_POS_BRATE +: 4];
  assign sr_idx   = hdr_q[FHV_POS_SRATE +: 2];

  always_comb begin
    br = 9'd0;
    if (hdr_q[FHV_POS_VER]) begin
      case (br_idx)
        4'h1: br = 9'd32;
        4'h2: br = 9'd40;
        4'h3: br = 9'd48;
        4'h4: br = 9'd56;
        4'h5: br = 9'd64;
        4'h6: br = 9'd80;
        4'h7: br = 9'd96;
        4'h8: br = 9'd112;
        4'h9: br = 9'd128;
        4'hA: br = 9'd160;
        4'hB: br = 9'd192;
        4'hC: br = 9'd224;
        4'hD: br = 9'd256;
        4'hE: br = 9'd320;
        default: br = 9'd0;
      endcase
    end else begin
      case (br_idx)
        4'h1: br = 9'd8;
        4'h2: br = 9'd16;
        4'h3: br = 9'd24;
        4'h4: br = 9'd32;
        4'h5: br = 9'd40;
        4'h6: br = 9'd48;
        4'h7: br = 9'd56;
        4'h8: br = 9'd64;
        4'h9: br = 9'd80;
        4'hA: br = 9'd96;
        4'hB: br = 9'd112;
        4'hC: br = 9'd128;
        4'hD: br = 9'd144;
        4'hE: br = 9'd160;
        default: br = 9'd0;
      endcase
    end
  end

  // sample rate in units of 10 Hz
  always_comb begin
    sr = 16'd0;
    case (sr_idx)
      2'b00: sr = 16'd4410;
      2'b01: sr = 16'd4800;
      2'b10: sr = 16'd3200;
      default: sr = 16'd0;
    endcase
    case (ver_bits)
      2'b10: sr = sr >> 1;
      2'b00: sr = sr >> 2;
      default: ;
    endcase
  end

  always_comb begin
    hdr_o.version      = fhv_ver_e'(ver_bits);
    hdr_o.layer_ok     = hdr_q[FHV_POS_LAYER +: 2] == FHV_LAYER_III;
    hdr_o.crc_present  = ~hdr_q[FHV_POS_PROT];
    hdr_o.bitrate_kbps = br;
    hdr_o.free_format  = br_idx == 4'h0;
    hdr_o.bad_bitrate  = br_idx == 4'hF;
    hdr_o.srate_10hz   = sr;
    hdr_o.bad_srate    = (sr_idx == 2'b11) || (ver_bits == 2'b01);
    hdr_o.extra_slot   = hdr_q[FHV_POS_PAD];
    hdr_o.chmode       = fhv_chmode_e'(hdr_q[FHV_POS_MODE +: 2]);
    hdr_o.joint_method = (hdr_q[FHV_POS_MODE +: 2] == 2'b01) ?
                         hdr_q[FHV_POS_MODEXT +: 2] : 2'b00;
    hdr_o.copyright    = hdr_q[FHV_POS_COPY];
    hdr_o.original     = hdr_q[FHV_POS_ORIG];
    hdr_o.emphasis     = fhv_emph_e'(hdr_q[FHV_POS_EMPH +: 2]);
    hdr_o.priv         = hdr_q[FHV_POS_PRIV];
  end

  // ==========================================================
  // volume and crossfeed path
  function automatic logic signed [15:0] scale(
    input logic signed [15:0] s,
    input logic [7:0]         att
  );
    logic signed [32:0] p;
    p = s * $signed({1'b0, fhv_att_gain(att)});
    return p[31:16];
  endfunction

  logic signed [15:0] l_att;
  logic signed [15:0] r_att;
  logic signed [15:0] x_att;
  logic signed [16:0] r_sum;

  assign l_att = scale($signed(left_i), lvol_q);
  assign r_att = scale($signed(right_i), rvol_q);
  assign x_att = scale($signed(left_i), xfeed_q);
  assign r_sum = 17'(r_att) + 17'(x_att);

  always_ff @(posedge clk_i) begin
    if (rst) begin
      left_o      <= 16'h0000;
      right_o     <= 16'h0000;
      out_valid_o <= 1'b0;
    end else begin
      out_valid_o <= smp_valid_i;
      if (smp_valid_i) begin
        left_o <= l_att;
        if (r_sum > 17'sd32767) begin
          right_o <= 16'h7FFF;
        end else if (r_sum < -17'sd32768) begin
          right_o <= 16'h8000;
        end else begin
          right_o <= r_sum[15:0];
        end
      end
    end
  end

endmodule

// *** fhv_regs_assertions.sv ***
// checker for the frame header and volume registers
// sees only the ports of fhv_regs, one clock domain
`timescale 1ns/1ps
module fhv_regs_chk
  import fhv_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        srst_i,
  input  wire logic        soft_rst_i,
  input  wire fhv_req_s    req_i,
  input  wire logic [7:0]  rdata_o,
  input  wire logic        rvalid_o,
  input  wire logic        frame_ok_i,
  input  wire logic [15:0] anc_bits_i,
  input  wire logic        sync_i,
  input  wire logic [20:0] header_i,
  input  wire logic        smp_valid_i,
  input  wire logic        out_valid_o,
  input  wire fhv_hdr_s    hdr_o
);
  // ==========================================================
  // properties
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  property p_rv;
    req_i.rd |=> rvalid_o;
  endproperty
  a_rv: assert property (p_rv)
    else $error("read not answered");
  property p_norv;
    !req_i.rd |=> !rvalid_o && rdata_o == 8'h00;
  endproperty
  a_norv: assert property (p_norv)
    else $error("read data without read");
  property p_anc;
    (frame_ok_i && !soft_rst_i) ##1 (req_i.rd && req_i.addr == 8'h42
      && !frame_ok_i && !soft_rst_i) |=> rdata_o == $past(anc_bits_i[15:8], 2);
  endproperty
  a_anc: assert property (p_anc)
    else $error("count high byte wrong");
  property p_hdr;
    (sync_i && !soft_rst_i) ##1 (req_i.rd && req_i.addr == 8'h44
      && !sync_i && !soft_rst_i) |=> rdata_o == $past(header_i[15:8], 2);
  endproperty
  a_hdr: assert property (p_hdr)
    else $error("header middle byte wrong");
  property p_top;
    req_i.rd && req_i.addr == 8'h43 |=> rdata_o[7:5] == 3'h0;
  endproperty
  a_top: assert property (p_top)
    else $error("header upper bits not zero");
  property p_ver;
    sync_i && !soft_rst_i |=> hdr_o.version == $past(header_i[20:19])
      && hdr_o.layer_ok == ($past(header_i[18:17]) == FHV_LAYER_III);
  endproperty
  a_ver: assert property (p_ver)
    else $error("version decode wrong");
  property p_mode;
    sync_i && !soft_rst_i |=> hdr_o.chmode == $past(header_i[7:6])
      && hdr_o.emphasis == $past(header_i[1:0])
      && hdr_o.crc_present == !$past(header_i[16]);
  endproperty
  a_mode: assert property (p_mode)
    else $error("mode decode wrong");
  property p_ov;
    smp_valid_i && !soft_rst_i |=> out_valid_o;
  endproperty
  a_ov: assert property (p_ov)
    else $error("sample not passed");
endmodule

bind fhv_regs fhv_regs_chk u_chk (.clk_i(clk_i), .srst_i(srst_i),
  .soft_rst_i(soft_rst_i), .req_i(req_i), .rdata_o(rdata_o),
  .rvalid_o(rvalid_o), .frame_ok_i(frame_ok_i), .anc_bits_i(anc_bits_i),
  .sync_i(sync_i), .header_i(header_i), .smp_valid_i(smp_valid_i),
  .out_valid_o(out_valid_o), .hdr_o(hdr_o));

// *** fhv_host.sv ***
// host model issuing register strobes
// tasks are entered just after a rising clock edge
`timescale 1ns/1ps
module fhv_host
  import fhv_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic [7:0] rdata_i,
  input  wire logic       rvalid_i,
  output fhv_req_s        req_o
);
  logic [7:0] got;
  initial req_o = '0;
  // ==========================================================
  // idle bus shows the inverse of the last value
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    req_o = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(posedge clk_i);
    #1 req_o = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
    // one idle edge so the next call never re-drives req_o in this step
    @(posedge clk_i);
    #1;
  endtask
  task automatic rd(input logic [7:0] a);
    req_o = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    @(posedge clk_i);
    #1 req_o = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: 8'hFF};
    got = rvalid_i ? rdata_i : 8'hXX;
    @(posedge clk_i);
    #1;
  endtask
endmodule

// *** fhv_regs_bench.sv ***
// self-checking bench for fhv_regs
// uses fhv_host as the register master
`timescale 1ns/1ps
module fhv_regs_bench
  import fhv_pkg::*;
;
  logic               clk_i;
  logic               srst_i;
  logic               soft_rst_i;
  fhv_req_s           req;
  logic [7:0]         rdata;
  logic               rvalid;
  logic               frame_ok;
  logic [15:0]        anc;
  logic               sync;
  logic [20:0]        hdr;
  logic               smp;
  logic signed [15:0] li;
  logic signed [15:0] ri;
  logic signed [15:0] lo;
  logic signed [15:0] ro;
  logic               ov;
  fhv_hdr_s           dec;
  int                 n_errors;
  int                 checks;

  fhv_regs u_fhv_regs (.clk_i(clk_i), .srst_i(srst_i),
    .soft_rst_i(soft_rst_i), .req_i(req), .rdata_o(rdata),
    .rvalid_o(rvalid), .frame_ok_i(frame_ok), .anc_bits_i(anc),
    .sync_i(sync), .header_i(hdr), .smp_valid_i(smp), .left_i(li),
    .right_i(ri), .left_o(lo), .right_o(ro), .out_valid_o(ov),
    .hdr_o(dec));
  fhv_host u_fhv_host (.clk_i(clk_i), .rdata_i(rdata), .rvalid_i(rvalid),
    .req_o(req));

  // ==========================================================
  // helpers
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic near(input logic signed [15:0] s,
                      input logic signed [15:0] e);
    logic signed [16:0] d;
    d = s - e;
    chk({31'h0, (d >= -17'sd2 && d <= 17'sd2)}, 32'h1);
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(posedge clk_i);
    #1 s = 1'b0;
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // ==========================================================
  // scenarios
  task automatic t_map(input logic wrt);
    for (int a = 8'h40; a <= 8'h49; a++) begin
      if (wrt) u_fhv_host.wr(8'(a), 8'hC3 ^ 8'(a));
      u_fhv_host.rd(8'(a));
      if (wrt && a >= 8'h46 && a <= 8'h48)
        chk(u_fhv_host.got, 8'hC3 ^ 8'(a));
      else chk(u_fhv_host.got, (a == 8'h47) ? 8'hFF : 8'h00);
    end
    $display("map test done");
  endtask
  task automatic t_hdr(input logic [20:0] h, input logic [26:0] n,
                       input logic [11:0] f, input logic [2:0] j);
    // layer field kept at 01 in every header
    hdr = h;
    pulse(sync);
    hdr = ~h;
    u_fhv_host.rd(8'h44);
    chk(u_fhv_host.got, h[15:8]);
    u_fhv_host.rd(8'h43);
    chk(u_fhv_host.got, {3'h0, h[20:16]});
    u_fhv_host.rd(8'h45);
    chk(u_fhv_host.got, h[7:0]);
    chk({dec.version, dec.bitrate_kbps, dec.srate_10hz}, n);
    chk({dec.free_format, dec.bad_bitrate, dec.bad_srate, dec.extra_slot,
      dec.chmode, dec.copyright, dec.original, dec.emphasis,
      dec.crc_present, dec.layer_ok}, f);
    chk({dec.joint_method, dec.priv}, j);
    $display("header test done");
  endtask
  task automatic t_vol(input logic [7:0] l, input logic [7:0] x,
                       input logic [7:0] r, input logic signed [15:0] el,
                       input logic signed [15:0] er);
    u_fhv_host.wr(8'h46, l);
    u_fhv_host.wr(8'h47, x);
    u_fhv_host.wr(8'h48, r);
    pulse(smp);
    chk(ov, 1'b1);
    near(lo, el);
    near(ro, er);
    $display("volume test done");
  endtask

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  initial begin
    repeat (5000) @(posedge clk_i);
    n_errors++;
    end_of_test();
  end
  initial begin
    {srst_i, soft_rst_i, frame_ok, sync, smp} = 5'h10;
    anc = 16'h0000;
    hdr = 21'h000000;
    li = 16'sd12000;
    ri = -16'sd8000;
    repeat (20) @(posedge clk_i);
    #1 srst_i = 1'b0;
    t_map(1'b0);
    t_map(1'b1);
    anc = 16'hA55A;
    pulse(frame_ok);
    anc = 16'h0000;
    u_fhv_host.rd(8'h42);
    chk(u_fhv_host.got, 8'hA5);
    u_fhv_host.rd(8'h41);
    chk(u_fhv_host.got, 8'h5A);
    t_hdr(21'h1BE26B, {2'd3, 9'd320, 16'd4410}, 12'h16D, 3'h4);
    t_hdr(21'h12E5C4, {2'd2, 9'd160, 16'd2400}, 12'h0D3, 3'h1);
    t_hdr(21'h030801, {2'd0, 9'd0, 16'd800}, 12'h805, 3'h0);
    t_hdr(21'h1BF400, {2'd3, 9'd0, 16'd4800}, 12'h401, 3'h0);
    t_vol(8'h00, 8'hFF, 8'h00, 16'sd12000, -16'sd8000);
    t_vol(8'h60, 8'hFF, 8'hFF, 16'sd0, 16'sd0);
    t_vol(8'h06, 8'h00, 8'h60, 16'sd6000, 16'sd12000);
    pulse(soft_rst_i);
    t_map(1'b0);
    end_of_test();
  end
endmodule
